// ===== hdl/hpsp_pkg.sv
// Shared constants, register map and state type of the haptic power/protection block
package hpsp_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int WDOG_TIME_NS = 4330000;
    localparam int WDOG_CYC_DEF = WDOG_TIME_NS / CLK_PERIOD_NS;
    localparam int OC_RECHECK_NS = 100000;
    localparam int OC_RECHECK_CYC = OC_RECHECK_NS / CLK_PERIOD_NS;
    localparam int RCHK_W = 12;
    localparam int RESTORE_CYC = 2;
    localparam int RST_CNT_W = 2;
    // ------------------------------------------------------------
    // Bus and register map (register index, byte address = 4 x index)
    // ------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int NUM_CFG = 5;
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_MODE = 8'h01;
    localparam logic [7:0] REG_GO = 8'h0C;
    localparam logic [7:0] REG_CFG_FIRST = 8'h16;
    localparam logic [7:0] REG_CFG_LAST = 8'h1A;
    localparam logic [7:0] REG_CTRL = 8'h1D;
    localparam logic [7:0] REG_VBAT = 8'h21;
    // ------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------
    localparam int MODE_FLD_LSB = 0;
    localparam int MODE_FLD_W = 3;
    localparam int MODE_STBY_BIT = 6;
    localparam int MODE_SRST_BIT = 7;
    localparam int GO_BIT = 0;
    localparam int STAT_OC_BIT = 0;
    localparam int STAT_OT_BIT = 1;
    localparam int STAT_STATE_LSB = 5;
    localparam int CTRL_NG_LSB = 0;
    localparam logic [2:0] MODE_ANALOG = 3'h3;
    localparam logic [7:0] MODE_RESET = 8'h40;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CFG_RESET = 8'h00;
    // ------------------------------------------------------------
    // Pin synchroniser slots
    // ------------------------------------------------------------
    localparam int NPIN = 6;
    localparam int PIN_EN = 0;
    localparam int PIN_OT = 1;
    localparam int PIN_SHORT = 2;
    localparam int PIN_REGS = 3;
    localparam int PIN_BO = 4;
    localparam int PIN_BUSY = 5;
    // ------------------------------------------------------------
    // Power states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_RESET = 3'b000,
        ST_SHUTDOWN = 3'b001,
        ST_STANDBY = 3'b010,
        ST_READY = 3'b011,
        ST_ACTIVE = 3'b100,
        ST_OC_HOLD = 3'b101
    } hpsp_state_t;
endpackage : hpsp_pkg

// ===== hdl/hpsp_wdog_if.sv
// Link between the power controller and the serial-protocol watchdog
`timescale 1ns/1ps
`default_nettype none
interface hpsp_wdog_if;
    logic busy;
    logic arm;
    logic expire;
    modport ctl (output busy, output arm, input expire);
    modport wd (input busy, input arm, output expire);
endinterface : hpsp_wdog_if
`default_nettype wire

// ===== hdl/hpsp_wdog.sv
// Serial-protocol stall watchdog
`timescale 1ns/1ps
`default_nettype none
module hpsp_wdog #(
    parameter int WDOG_CYC = hpsp_pkg::WDOG_CYC_DEF
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // Controller link
    hpsp_wdog_if.wd wd
);
    import hpsp_pkg::*;
    localparam int CNT_W = $clog2(WDOG_CYC + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(WDOG_CYC - 1);

    logic [CNT_W-1:0] cnt;
    logic expire;
    assign wd.expire = expire;

    // ------------------------------------------------------------
    // Stall counter
    // ------------------------------------------------------------
    // Counts only while armed and a transaction is open; disarmed means stalls stay stuck
    always_ff @(posedge clk_in) begin
        if (srst_in || !wd.arm || !wd.busy) begin
            cnt <= '0;
            expire <= 1'b0;
        end else if (cnt == CNT_LAST) begin
            cnt <= '0;
            expire <= 1'b1;
        end else begin
            cnt <= cnt + 1'b1;
            expire <= 1'b0;
        end
    end

    AST_WDOG_FIRE: assert property (@(posedge clk_in) disable iff (srst_in)
        (wd.arm && wd.busy && cnt == CNT_LAST) |=> (expire && cnt == '0))
        else $error("watchdog did not fire at its limit");
    AST_WDOG_IDLE_STBY: assert property (@(posedge clk_in) disable iff (srst_in)
        !wd.arm |=> !expire)
        else $error("watchdog fired while disarmed");
endmodule : hpsp_wdog
`default_nettype wire

// ===== hdl/hpsp_top.sv
// Power-state, protection and register logic of the haptic driver core
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Two-bit gate threshold in control register drives the analog/PWM noise gate.
// - While active, the supply measurement register follows the supply sample.
// - Configuration registers reload from programmed nonvolatile memory at every reset.
// - Standby keeps all registers and still serves bus accesses.
// - Watchdog resets the serial protocol after a 4.33 ms stall.
// - Watchdog is disarmed while in standby.
// - Over-temperature stops the driver and sets a status flag.
// - Output short latches the overcurrent flag and stops the driver.
// - Short is rechecked periodically; once gone the block restarts from defaults.
// - Regulator short holds the block in reset; release restarts from defaults.
// - Brownout or power-on reset holds the block in reset, then defaults.
// - Enable low enters shutdown without resetting registers.
// - Enable low still answers bus accesses but reads zero, ignores writes.
// - Standby bit resets to one, so the block starts in standby.
// - Setting standby stops any running process at once.
// - Clearing standby moves the block to ready.
// - Writing the soft-reset bit acts as a power cycle.
// - Soft-reset bit is never stored, so it always reads back as zero.
// - Shorts are only checked while a process runs.
// - After a short, the mode field must be rewritten before playback.
module hpsp_top #(
    parameter int WDOG_CYC = hpsp_pkg::WDOG_CYC_DEF
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [hpsp_pkg::ADDR_W-1:0] paddr_in,
    input wire logic [hpsp_pkg::DATA_W-1:0] pwdata_in,
    output logic [hpsp_pkg::DATA_W-1:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Asynchronous pins and detectors
    input wire logic en_pin_in,
    input wire logic over_temp_in,
    input wire logic out_short_in,
    input wire logic reg_short_in,
    input wire logic brownout_in,
    input wire logic i2c_busy_in,
    // Same-clock inputs
    input wire logic [7:0] vdd_level_in,
    input wire logic proc_done_in,
    input wire logic nvm_prog_in,
    input wire logic [8*hpsp_pkg::NUM_CFG-1:0] nvm_cfg_in,
    // Control outputs
    output logic drive_en_out,
    output logic gate_en_out,
    output logic [1:0] input_gate_threshold_out,
    output logic standby_out,
    output logic shutdown_out,
    output logic i2c_proto_rst_out,
    output logic [8*hpsp_pkg::NUM_CFG-1:0] cfg_out
);
    import hpsp_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [NPIN-1:0] pin_meta;
    logic [NPIN-1:0] pin_sync;
    logic en_s, ot_s, short_s, regs_s, bo_s, busy_s;

    // Two stages; only pin_sync is read by the logic
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= {i2c_busy_in, brownout_in, reg_short_in,
                         out_short_in, over_temp_in, en_pin_in};
            pin_sync <= pin_meta;
        end
    end

    assign en_s = pin_sync[PIN_EN];
    assign ot_s = pin_sync[PIN_OT];
    assign short_s = pin_sync[PIN_SHORT];
    assign regs_s = pin_sync[PIN_REGS];
    assign bo_s = pin_sync[PIN_BO];
    assign busy_s = pin_sync[PIN_BUSY];

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    hpsp_state_t state, next_state;
    logic hard_rst;
    logic [RST_CNT_W-1:0] rst_cnt;
    logic rst_done;
    logic [RCHK_W-1:0] rchk_cnt;
    logic rchk_tick;
    logic [7:0] mode_reg, ctrl_reg, vbat_reg;
    logic go_reg, ot_flag, oc_flag, short_seen;
    logic [7:0] cfg [NUM_CFG];
    logic bus_acc, bus_ok, mapped, wr_take, rd_ok;
    logic [7:0] reg_idx, rd_val;
    logic wr_mode, wr_ctrl, wr_go, wr_stat, soft_req;
    logic [7:0] cfg_off;

    // Regulator short and brownout behave like power-on reset
    assign hard_rst = srst_in | bo_s | regs_s;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    // First access cycle only; pready is registered so every transfer waits one cycle
    assign bus_acc = psel_in & penable_in & ~pready_out;
    assign reg_idx = paddr_in[9:2];
    assign cfg_off = reg_idx - REG_CFG_FIRST;

    // Known register at an aligned word address
    always_comb begin
        mapped = 1'b0;
        if (paddr_in[1:0] == 2'h0 && paddr_in[ADDR_W-1:10] == '0) begin
            mapped = (reg_idx == REG_STATUS) || (reg_idx == REG_MODE) ||
                     (reg_idx == REG_GO) || (reg_idx == REG_CTRL) ||
                     (reg_idx == REG_VBAT) ||
                     (reg_idx >= REG_CFG_FIRST && reg_idx <= REG_CFG_LAST);
        end
    end

    // Enable low still completes the transfer but touches nothing
    assign bus_ok = en_s & (state != ST_RESET);
    assign wr_take = bus_acc & pwrite_in & mapped & bus_ok;
    assign rd_ok = ~pwrite_in & mapped & bus_ok;
    assign wr_mode = wr_take & (reg_idx == REG_MODE);
    assign wr_ctrl = wr_take & (reg_idx == REG_CTRL);
    assign wr_go = wr_take & (reg_idx == REG_GO);
    assign wr_stat = wr_take & (reg_idx == REG_STATUS);
    assign soft_req = wr_mode & pwdata_in[MODE_SRST_BIT];

    // ------------------------------------------------------------
    // Power state machine
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            state <= ST_RESET;
        end else begin
            state <= next_state;
        end
    end

    // Reset length counter; held at zero while a hard source stays active
    always_ff @(posedge clk_in) begin
        if (hard_rst || state != ST_RESET) begin
            rst_cnt <= '0;
        end else if (!rst_done) begin
            rst_cnt <= rst_cnt + 1'b1;
        end
    end
    assign rst_done = (rst_cnt == RST_CNT_W'(RESTORE_CYC - 1));

    // Short recheck timer, runs only during overcurrent hold
    always_ff @(posedge clk_in) begin
        if (srst_in || state != ST_OC_HOLD || rchk_tick) begin
            rchk_cnt <= '0;
        end else begin
            rchk_cnt <= rchk_cnt + 1'b1;
        end
    end
    assign rchk_tick = (rchk_cnt == RCHK_W'(OC_RECHECK_CYC - 1));

    // Priority: hard reset, soft reset, overcurrent hold, enable, standby
    always_comb begin
        next_state = state;
        if (hard_rst) begin
            next_state = ST_RESET;
        end else if (state == ST_RESET) begin
            if (rst_done) begin
                next_state = ST_STANDBY;
            end
        end else if (soft_req) begin
            next_state = ST_RESET;
        end else if (state == ST_OC_HOLD) begin
            if (rchk_tick && !short_s) begin
                next_state = ST_RESET;
            end
        end else if (!en_s) begin
            next_state = ST_SHUTDOWN;
        end else if (mode_reg[MODE_STBY_BIT]) begin
            next_state = ST_STANDBY;
        end else begin
            case (state)
                ST_ACTIVE: begin
                    if (short_s) begin
                        next_state = ST_OC_HOLD;
                    end else if (!go_reg || ot_s) begin
                        next_state = ST_READY;
                    end
                end
                ST_READY: begin
                    if (go_reg && !short_seen && !ot_s) begin
                        next_state = ST_ACTIVE;
                    end
                end
                ST_SHUTDOWN, ST_STANDBY: begin
                    next_state = ST_READY;
                end
                default: begin
                    next_state = ST_RESET;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Mode: standby set by default; the soft-reset bit is never stored
    always_ff @(posedge clk_in) begin
        if (srst_in || state == ST_RESET) begin
            mode_reg <= MODE_RESET;
        end else if (wr_mode) begin
            mode_reg <= pwdata_in[7:0] & ~(8'h01 << MODE_SRST_BIT);
        end
    end

    // Control register carrying the gate threshold
    always_ff @(posedge clk_in) begin
        if (srst_in || state == ST_RESET) begin
            ctrl_reg <= CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_reg <= pwdata_in[7:0];
        end
    end

    // Process launch bit; dropped when the process ends or is stopped
    always_ff @(posedge clk_in) begin
        if (srst_in || state == ST_RESET) begin
            go_reg <= 1'b0;
        end else if (wr_go) begin
            go_reg <= pwdata_in[GO_BIT];
        end else if (proc_done_in || (state == ST_ACTIVE && next_state != ST_ACTIVE)) begin
            go_reg <= 1'b0;
        end
    end

    // Over-temperature flag: write one to clear, a new event wins
    always_ff @(posedge clk_in) begin
        if (srst_in || state == ST_RESET) begin
            ot_flag <= 1'b0;
        end else if (ot_s) begin
            ot_flag <= 1'b1;
        end else if (wr_stat && pwdata_in[STAT_OT_BIT]) begin
            ot_flag <= 1'b0;
        end
    end

    // Overcurrent flag stays until the short is gone and the restart clears it
    always_ff @(posedge clk_in) begin
        if (srst_in || state == ST_RESET) begin
            oc_flag <= 1'b0;
        end else if (state == ST_ACTIVE && short_s) begin
            oc_flag <= 1'b1;
        end
    end

    // Survives the overcurrent restart so playback waits for a new mode write
    always_ff @(posedge clk_in) begin
        if (hard_rst) begin
            short_seen <= 1'b0;
        end else if (state == ST_ACTIVE && short_s) begin
            short_seen <= 1'b1;
        end else if (wr_mode) begin
            short_seen <= 1'b0;
        end
    end

    // Supply measurement follows the sample only while playing
    always_ff @(posedge clk_in) begin
        if (srst_in || state == ST_RESET) begin
            vbat_reg <= 8'h00;
        end else if (state == ST_ACTIVE) begin
            vbat_reg <= vdd_level_in;
        end
    end

    // Retained configuration, reloaded on every reset from memory if programmed, else defaults
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CFG; gi++) begin : g_cfg
            always_ff @(posedge clk_in) begin
                if (srst_in) begin
                    cfg[gi] <= CFG_RESET;
                end else if (state == ST_RESET) begin
                    cfg[gi] <= nvm_prog_in ? nvm_cfg_in[8*gi +: 8] : CFG_RESET;
                end else if (wr_take && cfg_off == 8'(gi) &&
                             reg_idx >= REG_CFG_FIRST && reg_idx <= REG_CFG_LAST) begin
                    cfg[gi] <= pwdata_in[7:0];
                end
            end
            assign cfg_out[8*gi +: 8] = cfg[gi];
        end
    endgenerate

    // ------------------------------------------------------------
    // Read path and bus answer
    // ------------------------------------------------------------
    // Register read mux; unmapped and blocked reads give zero
    always_comb begin
        rd_val = 8'h00;
        if (reg_idx == REG_STATUS) begin
            rd_val[STAT_OC_BIT] = oc_flag;
            rd_val[STAT_OT_BIT] = ot_flag;
            rd_val[STAT_STATE_LSB +: 3] = state;
        end else if (reg_idx == REG_MODE) begin
            rd_val = mode_reg;
        end else if (reg_idx == REG_GO) begin
            rd_val[GO_BIT] = go_reg;
        end else if (reg_idx == REG_CTRL) begin
            rd_val = ctrl_reg;
        end else if (reg_idx == REG_VBAT) begin
            rd_val = vbat_reg;
        end else if (reg_idx >= REG_CFG_FIRST && reg_idx <= REG_CFG_LAST) begin
            rd_val = cfg[cfg_off[2:0]];
        end
    end

    // One wait state on every transfer
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= '0;
        end else begin
            pready_out <= bus_acc;
            pslverr_out <= bus_acc & ~mapped;
            if (bus_acc) begin
                prdata_out <= rd_ok ? {24'h000000, rd_val} : '0;
            end
        end
    end

    // ------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------
    hpsp_wdog_if wd_if ();
    assign wd_if.busy = busy_s;
    assign wd_if.arm = (state != ST_STANDBY);

    hpsp_wdog #(
        .WDOG_CYC(WDOG_CYC)
    ) u_wdog (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .wd(wd_if.wd)
    );

    // ------------------------------------------------------------
    // Control outputs
    // ------------------------------------------------------------
    // Registered from the next state so outputs track the state register
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            drive_en_out <= 1'b0;
            gate_en_out <= 1'b0;
            input_gate_threshold_out <= 2'h0;
            standby_out <= 1'b0;
            shutdown_out <= 1'b0;
            i2c_proto_rst_out <= 1'b0;
        end else begin
            drive_en_out <= (next_state == ST_ACTIVE) & ~ot_s;
            gate_en_out <= (next_state == ST_ACTIVE) &&
                           (mode_reg[MODE_FLD_LSB +: MODE_FLD_W] == MODE_ANALOG);
            input_gate_threshold_out <= ctrl_reg[CTRL_NG_LSB +: 2];
            standby_out <= (next_state == ST_STANDBY);
            shutdown_out <= (next_state == ST_SHUTDOWN);
            i2c_proto_rst_out <= wd_if.expire;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_COME_UP_STBY: assert property (@(posedge clk_in) disable iff (hard_rst)
        (state == ST_RESET && rst_done && !soft_req) |=> state == ST_STANDBY)
        else $error("reset did not end in standby");
    AST_STBY_STOPS: assert property (@(posedge clk_in) disable iff (srst_in)
        (wr_mode && pwdata_in[MODE_STBY_BIT] && state == ST_ACTIVE && !hard_rst)
        |-> ##2 !drive_en_out)
        else $error("standby did not stop the driver");
    AST_EN_LOW_NO_WR: assert property (@(posedge clk_in) disable iff (srst_in)
        (!en_s && bus_acc && pwrite_in && state != ST_RESET)
        |=> $stable(mode_reg) && $stable(ctrl_reg))
        else $error("write landed with enable low");
    AST_SOFT_RESET: assert property (@(posedge clk_in) disable iff (hard_rst)
        soft_req |=> (state == ST_RESET) [*2] ##1 mode_reg == MODE_RESET)
        else $error("soft reset sequence wrong");
    AST_OT_FLAG: assert property (@(posedge clk_in) disable iff (srst_in)
        (ot_s && state != ST_RESET && next_state != ST_RESET)
        |=> ot_flag && !drive_en_out)
        else $error("over-temperature not flagged");
    AST_OC_LATCH: assert property (@(posedge clk_in) disable iff (hard_rst)
        (state == ST_ACTIVE && short_s && !soft_req)
        |=> oc_flag && state == ST_OC_HOLD)
        else $error("short not latched");
    AST_OC_ONLY_ACTIVE: assert property (@(posedge clk_in) disable iff (srst_in)
        $rose(oc_flag) |-> $past(state) == ST_ACTIVE)
        else $error("short flagged outside a process");
    AST_OC_RECOVER: assert property (@(posedge clk_in) disable iff (hard_rst)
        (state == ST_OC_HOLD && rchk_tick && !short_s) |=> state == ST_RESET)
        else $error("no restart after short cleared");
    AST_VBAT_TRACK: assert property (@(posedge clk_in) disable iff (hard_rst)
        (state == ST_ACTIVE) |=> vbat_reg == $past(vdd_level_in))
        else $error("supply measurement stale");
    AST_HARD_FIRST: assert property (@(posedge clk_in)
        hard_rst |=> state == ST_RESET)
        else $error("hard reset lost priority");
endmodule : hpsp_top
`default_nettype wire

// ===== sim/hpsp_host.sv
// Host-side model: enable pin and serial-bus activity seen by the block
`timescale 1ns/1ps
`default_nettype none
module hpsp_host (
    // Clock and requests from the bench
    input wire logic clk_in,
    input wire logic en_req_in,
    input wire logic busy_req_in,
    // Pins toward the block
    output logic en_pin_out,
    output logic i2c_busy_out
);
    // Pins move only after an edge; enable goes up before any write meant to land
    always_ff @(posedge clk_in) begin
        en_pin_out <= en_req_in;
        i2c_busy_out <= busy_req_in;
    end
endmodule : hpsp_host
`default_nettype wire

// ===== sim/tb_top.sv
// Self-checking bench for the haptic power and protection block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import hpsp_pkg::*;
    logic clk_in, srst_in, psel_in, penable_in, pwrite_in, ot, osh, en_req, busy_req, en_pin, busy;
    logic pready_out, err, drv, gate, stby, shdn, wdr, bo, nvp, rd_err;
    logic [39:0] nvc, cfgo;
    logic [11:0] paddr_in;
    logic [31:0] pwdata_in, prdata_out, rd;
    logic [1:0] thr;
    logic [7:0] vdd;
    int n_errors, total_checks, k;
    hpsp_top #(.WDOG_CYC(20)) u_dut (.clk_in(clk_in), .srst_in(srst_in), .psel_in(psel_in),
        .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
        .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
        .pslverr_out(err), .en_pin_in(en_pin), .over_temp_in(ot), .out_short_in(osh),
        .reg_short_in(1'b0), .brownout_in(bo), .i2c_busy_in(busy), .vdd_level_in(vdd),
        .proc_done_in(1'b0), .nvm_prog_in(nvp), .nvm_cfg_in(nvc), .drive_en_out(drv),
        .gate_en_out(gate), .input_gate_threshold_out(thr), .standby_out(stby),
        .shutdown_out(shdn), .i2c_proto_rst_out(wdr), .cfg_out(cfgo));
    hpsp_host u_host (.clk_in(clk_in), .en_req_in(en_req), .busy_req_in(busy_req),
        .en_pin_out(en_pin), .i2c_busy_out(busy));
    // Free-running 40 MHz clock
    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end
    task automatic results();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : results
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        total_checks++;
        if (s !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    // One APB transfer; request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= {2'b00, idx, 2'b00};
        pwdata_in <= {24'h0, wd};
        @(posedge clk_in);
        penable_in <= 1'b1;
        for (k = 0; k < 50 && pready_out !== 1'b1; k++) @(posedge clk_in);
        if (k == 50) begin
            n_errors++;
            results();
        end
        rd = prdata_out;
        rd_err = err;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        // Idle edge, so a following call never raises psel in the same time step
        @(posedge clk_in);
    endtask : apb
    task automatic t_regs();
        apb(0, REG_MODE, 0); chk("mode", 32'h40, rd);
        apb(1, 8'h16, 8'hA5); apb(1, REG_CTRL, 8'h02); apb(0, 8'h16, 0);
        chk("cfg_stby", 32'hA5, rd); chk("thr", 32'h2, {30'h0, thr});
        apb(0, 8'h3F, 0); chk("unmapped", 32'h1, {31'h0, rd_err});
        en_req <= 1'b0; repeat (8) @(posedge clk_in);
        chk("shdn", 32'h1, {31'h0, shdn}); apb(1, 8'h16, 8'h3C); apb(0, 8'h16, 0);
        chk("blocked_rd", 32'h0, rd); en_req <= 1'b1; repeat (8) @(posedge clk_in);
        apb(0, 8'h16, 0); chk("cfg_kept", 32'hA5, rd);
    endtask : t_regs
    task automatic t_wdog();
        int p;
        busy_req <= 1'b1; p = 0;
        repeat (60) @(posedge clk_in) p += wdr;
        chk("wd_stby", 32'h0, p); apb(1, REG_MODE, 8'h00); p = 0;
        repeat (60) @(posedge clk_in) p += wdr;
        chk("ready", 32'h0, {31'h0, stby}); chk("wd_run", 32'h1, {31'h0, p > 0});
        busy_req <= 1'b0;
    endtask : t_wdog
    task automatic t_fault();
        apb(1, REG_MODE, MODE_ANALOG); apb(1, REG_GO, 8'h01); vdd <= 8'h9C;
        repeat (4) @(posedge clk_in); chk("gate", 32'h1, {31'h0, gate});
        apb(0, REG_VBAT, 0); chk("vbat", 32'h9C, rd); ot <= 1'b1;
        repeat (6) @(posedge clk_in); chk("ot_drv", 32'h0, {31'h0, drv}); ot <= 1'b0;
        apb(0, REG_STATUS, 0); chk("ot_flag", 32'h2, rd & 32'h3);
        apb(1, REG_STATUS, 8'h02); osh <= 1'b1; repeat (6) @(posedge clk_in);
        apb(0, REG_STATUS, 0); chk("oc_idle", 32'h0, rd & 32'h3);
        apb(1, REG_GO, 8'h01); repeat (6) @(posedge clk_in);
        apb(0, REG_STATUS, 0); chk("oc_flag", 32'h1, rd & 32'h3);
        chk("oc_drv", 32'h0, {31'h0, drv}); osh <= 1'b0;
        for (k = 0; k < 4200 && stby !== 1'b1; k++) @(posedge clk_in);
        chk("restart", 32'h1, {31'h0, stby});
        if (stby !== 1'b1) results();
        apb(0, REG_MODE, 0); chk("mode_def", 32'h40, rd);
        apb(0, REG_STATUS, 0); chk("oc_clr", 32'h0, rd & 32'h3);
    endtask : t_fault
    task automatic t_srst();
        apb(1, 8'h17, 8'h5A); apb(1, REG_MODE, 8'h80); repeat (10) @(posedge clk_in);
        apb(0, REG_MODE, 0); chk("srst_bit", 32'h40, rd);
        apb(0, 8'h17, 0); chk("cfg_def", 32'h0, rd);
    endtask : t_srst
    // Brownout while in standby with programmed memory: defaults come back, config reloads
    task automatic t_bo();
        nvc <= 40'h1122334455; nvp <= 1'b1;
        apb(1, 8'h18, 8'hC3); apb(1, REG_MODE, 8'h43);
        bo <= 1'b1; repeat (6) @(posedge clk_in);
        chk("bo_stby", 32'h0, {31'h0, stby}); bo <= 1'b0; repeat (10) @(posedge clk_in);
        apb(0, REG_MODE, 0); chk("bo_mode", 32'h40, rd);
        apb(0, 8'h18, 0); chk("nvm_cfg", 32'h33, rd);
        chk("cfg_out", 32'h33, {24'h0, cfgo[23:16]}); chk("bo_up", 32'h1, {31'h0, stby});
    endtask : t_bo
    // Main sequence: every input known at time zero, reset held 20 cycles
    initial begin
        {srst_in, psel_in, penable_in, pwrite_in, ot, osh, busy_req} = 7'h40;
        {paddr_in, pwdata_in, vdd, en_req} = 53'h1;
        {bo, nvp, nvc} = 42'h0;
        n_errors = 0; total_checks = 0;
        repeat (20) @(posedge clk_in);
        srst_in <= 1'b0;
        repeat (10) @(posedge clk_in);
        t_regs(); t_wdog(); t_fault(); t_srst(); t_bo();
        results();
    end
endmodule : tb_top
`default_nettype wire
